/* File: core/fpes_sequencer.sv */
// Overview of operation
// - Divider accepts only the first write.
// - Divider write blocked while access error set.
// - Pulses timed in whole flash clock periods.
// - Byte program and first burst byte 9 periods, chained burst byte 4.
// - Page erase 4000, mass erase 20000 periods.
// - Sequence violation sets error, command discarded.
// - Command before divider written is an error.
// - Stop entry during a command is an error.
// - Write one clears access error; zero ignored.
// - Blank flag set only if array erased.
// - Blank flag clears on valid launch only.
// - Codes 05 blank, 20 byte, 25 burst.
// - Codes 40 page erase, 41 mass erase.
// - Any other command code is an error.
// - 512-byte pages, 32 or 64 pages.
//
// Chosen here: the AHB-Lite register port and the register offsets.
module fpes_sequencer #(
   parameter int PAGES = 64,
   parameter int DIV_W = 11,
   parameter int PAGE_ERASE_CYCLES = fpes_pkg::PAGE_ERASE_TICKS,
   parameter int MASS_ERASE_CYCLES = fpes_pkg::MASS_ERASE_TICKS,
   parameter int BLANK_CHECK_CYCLES = fpes_pkg::BLANK_CHECK_TICKS
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic stop_entry,
   input wire logic array_blank,
   output logic array_program,
   output logic array_erase,
   output logic array_mass,
   output logic array_verify,
   output logic [$clog2(PAGES*fpes_pkg::PAGE_BYTES)-1:0] array_addr,
   output logic [7:0] array_data,
   output logic irq
);
   localparam int AW = $clog2(PAGES * fpes_pkg::PAGE_BYTES);
   localparam int PW = $clog2(fpes_pkg::PAGE_BYTES);

   if (PAGES != 32 && PAGES != 64) begin : g_chk_pages
      $error("PAGES must be 32 or 64");
   end
   // Bit 31 of the divider readback holds the loaded flag
   if (DIV_W < 1 || DIV_W > 30) begin : g_chk_div
      $error("DIV_W out of range");
   end
   if (MASS_ERASE_CYCLES >= 2 ** fpes_pkg::CNT_W) begin : g_chk_mass
      $error("erase count too wide");
   end
   if (PAGE_ERASE_CYCLES >= 2 ** fpes_pkg::CNT_W) begin : g_chk_page
      $error("page count too wide");
   end
   if (BLANK_CHECK_CYCLES >= 2 ** fpes_pkg::CNT_W) begin : g_chk_blank
      $error("blank count too wide");
   end
   if (PAGE_ERASE_CYCLES <= 5 || MASS_ERASE_CYCLES <= 5 || BLANK_CHECK_CYCLES <= 5)
   begin : g_chk_short
      $error("command too short");
   end

   localparam logic [14:0] T_START = 15'(fpes_pkg::START_TICKS - 1);
   localparam logic [14:0] T_END = 15'(fpes_pkg::END_TICKS - 1);
   localparam int OVH = fpes_pkg::START_TICKS + fpes_pkg::END_TICKS;
   localparam logic [14:0] T_BYTE = 15'(fpes_pkg::BYTE_PROG_TICKS - OVH - 1);
   localparam logic [14:0] T_BURST = 15'(fpes_pkg::BURST_BYTE_TICKS - 1);
   localparam logic [14:0] T_PAGE = 15'(PAGE_ERASE_CYCLES - OVH - 1);
   localparam logic [14:0] T_MASS = 15'(MASS_ERASE_CYCLES - OVH - 1);
   localparam logic [14:0] T_BLANK = 15'(BLANK_CHECK_CYCLES - OVH - 1);

   // Bus side state
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [31:0] hrdata_r;
   logic hreadyout_r;
   logic hresp_r;
   // Control and status
   logic [DIV_W-1:0] div_val_r;
   logic div_loaded_r;
   logic [DIV_W-1:0] div_cnt_r;
   logic acc_err_r;
   logic blank_r;
   logic [7:0] cmd_r;
   logic cmd_wr_r;
   logic [AW-1:0] addr_r;
   logic [7:0] data_r;
   logic pending_r;
   logic [1:0] irq_stat_r;
   logic [1:0] irq_mask_r;
   logic irq_r;
   // Sequencer
   fpes_pkg::fpes_state_type state_r, state_nxt;
   logic [14:0] cnt_r, cnt_nxt;
   logic [7:0] cur_cmd_r, cur_cmd_nxt;
   logic [AW-1:0] cur_addr_r, cur_addr_nxt;
   logic [7:0] cur_data_r, cur_data_nxt;
   logic take, done, stop_err;
   logic prog_r, erase_r, mass_r, verify_r;
   logic [AW-1:0] addr_out_r;

   // Address phase decode
   wire [7:0] a_ofs = haddr[7:0];
   wire ahb_go = hsel & htrans[1] & hready;
   wire rd_go = ahb_go & ~hwrite;
   wire wr_go = ahb_go & hwrite;

   // Data phase write strobes
   wire w_div = wr_pend_r && wr_addr_r == fpes_pkg::OFS_DIVIDER;
   wire w_stat = wr_pend_r && wr_addr_r == fpes_pkg::OFS_STATUS;
   wire w_cmd = wr_pend_r && wr_addr_r == fpes_pkg::OFS_COMMAND;
   wire w_addr = wr_pend_r && wr_addr_r == fpes_pkg::OFS_ADDRESS;
   wire w_data = wr_pend_r && wr_addr_r == fpes_pkg::OFS_DATA;
   wire w_mask = wr_pend_r && wr_addr_r == fpes_pkg::OFS_IRQ_MASK;

   wire cbef = ~pending_r;
   wire ccf = (state_r == fpes_pkg::FPES_IDLE) & ~pending_r;

   wire cmd_legal = cmd_r == fpes_pkg::CMD_BLANK || cmd_r == fpes_pkg::CMD_BYTE_PROG
      || cmd_r == fpes_pkg::CMD_BURST_PROG || cmd_r == fpes_pkg::CMD_PAGE_ERASE
      || cmd_r == fpes_pkg::CMD_MASS_ERASE;

   // Launch: write one to the buffer empty flag
   wire launch_try = w_stat & hwdata[fpes_pkg::ST_CBEF_BIT] & cbef & ~acc_err_r;
   wire launch_ok = launch_try & cmd_wr_r & cmd_legal & div_loaded_r;
   wire launch_err = launch_try & ~launch_ok;
   // Loading the buffer while it is still full breaks the sequence
   wire seq_err = (w_cmd | w_addr | w_data) & ~cbef;
   wire acc_set = launch_err | seq_err | stop_err;
   wire acc_clr = w_stat & hwdata[fpes_pkg::ST_ACCERR_BIT];

   // Divided flash timing clock as a one-cycle tick
   wire flash_timing_clock_tick = div_loaded_r & (div_cnt_r == div_val_r);

   wire [7:0] status_val = {cbef, ccf, 1'b0, acc_err_r, 1'b0, blank_r, 2'b00};
   wire [31:0] div_rd = {div_loaded_r, {(31 - DIV_W){1'b0}}, div_val_r};
   wire [31:0] rd_mux =
      (a_ofs == fpes_pkg::OFS_DIVIDER) ? div_rd :
      (a_ofs == fpes_pkg::OFS_STATUS) ? {24'h0, status_val} :
      (a_ofs == fpes_pkg::OFS_COMMAND) ? {24'h0, cmd_r} :
      (a_ofs == fpes_pkg::OFS_ADDRESS) ? {{(32 - AW){1'b0}}, addr_r} :
      (a_ofs == fpes_pkg::OFS_DATA) ? {24'h0, data_r} :
      (a_ofs == fpes_pkg::OFS_IRQ_STATUS) ? {30'h0, irq_stat_r} :
      (a_ofs == fpes_pkg::OFS_IRQ_MASK) ? {30'h0, irq_mask_r} : 32'h0;
   wire irq_rd = rd_go && a_ofs == fpes_pkg::OFS_IRQ_STATUS;
   wire [1:0] irq_set = {acc_set, done};
   // Set beats the read-clear so no event is lost
   wire [1:0] irq_stat_nxt = irq_set | (irq_rd ? 2'b00 : irq_stat_r);

   wire pulse_end = flash_timing_clock_tick && cnt_r == 15'h0;
   wire next_burst = pending_r && cmd_r == fpes_pkg::CMD_BURST_PROG
      && cur_cmd_r == fpes_pkg::CMD_BURST_PROG;

   function automatic logic [14:0] pulse_len(input logic [7:0] c);
      case (c)
         fpes_pkg::CMD_BYTE_PROG: pulse_len = T_BYTE;
         fpes_pkg::CMD_BURST_PROG: pulse_len = T_BYTE;
         fpes_pkg::CMD_PAGE_ERASE: pulse_len = T_PAGE;
         fpes_pkg::CMD_MASS_ERASE: pulse_len = T_MASS;
         default: pulse_len = T_BLANK;
      endcase
   endfunction

   // Sequencer next state; all waits count whole flash clock ticks
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      cur_cmd_nxt = cur_cmd_r;
      cur_addr_nxt = cur_addr_r;
      cur_data_nxt = cur_data_r;
      take = 1'b0;
      done = 1'b0;
      stop_err = 1'b0;
      if (flash_timing_clock_tick && cnt_r != 15'h0) begin
         cnt_nxt = cnt_r - 15'h1;
      end
      case (state_r)
         fpes_pkg::FPES_IDLE: begin
            if (pending_r) begin
               take = 1'b1;
               state_nxt = fpes_pkg::FPES_START;
               cnt_nxt = T_START;
            end
         end
         fpes_pkg::FPES_START: begin
            if (pulse_end) begin
               state_nxt = fpes_pkg::FPES_PULSE;
               cnt_nxt = pulse_len(cur_cmd_r);
            end
         end
         fpes_pkg::FPES_PULSE: begin
            if (pulse_end && next_burst) begin
               // Chained burst byte skips start and end overhead
               take = 1'b1;
               cnt_nxt = T_BURST;
            end else if (pulse_end) begin
               state_nxt = fpes_pkg::FPES_FINISH;
               cnt_nxt = T_END;
            end
         end
         fpes_pkg::FPES_FINISH: begin
            if (pulse_end) begin
               state_nxt = fpes_pkg::FPES_IDLE;
               done = 1'b1;
            end
         end
         default: state_nxt = fpes_pkg::FPES_IDLE;
      endcase
      if (take) begin
         cur_cmd_nxt = cmd_r;
         cur_addr_nxt = addr_r;
         cur_data_nxt = data_r;
      end
      // Stop aborts the command; the array sees its strobes drop at the next clock edge
      if (stop_entry && state_r != fpes_pkg::FPES_IDLE) begin
         stop_err = 1'b1;
         state_nxt = fpes_pkg::FPES_IDLE;
         cnt_nxt = 15'h0;
         take = 1'b0;
         done = 1'b0;
      end
   end

   wire pulse_nxt = state_nxt == fpes_pkg::FPES_PULSE;
   wire is_prog = cur_cmd_nxt == fpes_pkg::CMD_BYTE_PROG
      || cur_cmd_nxt == fpes_pkg::CMD_BURST_PROG;
   wire is_page = cur_cmd_nxt == fpes_pkg::CMD_PAGE_ERASE;
   wire is_mass = cur_cmd_nxt == fpes_pkg::CMD_MASS_ERASE;
   wire is_blank = cur_cmd_nxt == fpes_pkg::CMD_BLANK;
   wire blank_done = done && cur_cmd_r == fpes_pkg::CMD_BLANK;
   // Page erase drives a page-aligned address
   wire [AW-1:0] page_base = {cur_addr_nxt[AW-1:PW], {PW{1'b0}}};
   // Registered so the array address never glitches through a mux
   wire [AW-1:0] addr_out_nxt = (pulse_nxt & (is_page | is_mass)) ? page_base : cur_addr_nxt;

   // Bus slave
   always_ff @(posedge clock) begin
      if (rst) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         hrdata_r <= 32'h0;
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
      end else begin
         wr_pend_r <= wr_go;
         wr_addr_r <= a_ofs;
         hrdata_r <= rd_go ? rd_mux : 32'h0;
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
      end
   end

   // Divider, write-once and counted as divide by value plus one
   always_ff @(posedge clock) begin
      if (rst) begin
         div_val_r <= DIV_W'(fpes_pkg::DIVIDER_RESET);
         div_loaded_r <= 1'b0;
         div_cnt_r <= '0;
      end else begin
         if (w_div && !div_loaded_r && !acc_err_r) begin
            div_val_r <= hwdata[DIV_W-1:0];
            div_loaded_r <= 1'b1;
         end
         if (!div_loaded_r || flash_timing_clock_tick) begin
            div_cnt_r <= '0;
         end else begin
            div_cnt_r <= div_cnt_r + DIV_W'(1);
         end
      end
   end

   // Command buffer and flags
   always_ff @(posedge clock) begin
      if (rst) begin
         acc_err_r <= 1'b0;
         blank_r <= 1'b0;
         cmd_r <= fpes_pkg::COMMAND_RESET;
         cmd_wr_r <= 1'b0;
         addr_r <= '0;
         data_r <= 8'h00;
         pending_r <= 1'b0;
      end else begin
         acc_err_r <= acc_set | (acc_err_r & ~acc_clr);
         if (launch_ok) begin
            blank_r <= 1'b0;
         end else if (blank_done) begin
            blank_r <= array_blank;
         end
         if (w_cmd && cbef) begin
            cmd_r <= hwdata[7:0];
         end
         if (w_addr && cbef) begin
            addr_r <= hwdata[AW-1:0];
         end
         if (w_data && cbef) begin
            data_r <= hwdata[7:0];
         end
         // A refused launch discards the command as well
         if (launch_try) begin
            cmd_wr_r <= 1'b0;
         end else if (w_cmd && cbef) begin
            cmd_wr_r <= 1'b1;
         end
         if (launch_ok) begin
            pending_r <= 1'b1;
         end else if (take) begin
            pending_r <= 1'b0;
         end
      end
   end

   // Sequencer and array strobes
   always_ff @(posedge clock) begin
      if (rst) begin
         state_r <= fpes_pkg::FPES_IDLE;
         cnt_r <= 15'h0;
         cur_cmd_r <= fpes_pkg::COMMAND_RESET;
         cur_addr_r <= '0;
         cur_data_r <= 8'h00;
         prog_r <= 1'b0;
         erase_r <= 1'b0;
         mass_r <= 1'b0;
         verify_r <= 1'b0;
         addr_out_r <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         cur_cmd_r <= cur_cmd_nxt;
         cur_addr_r <= cur_addr_nxt;
         cur_data_r <= cur_data_nxt;
         prog_r <= pulse_nxt & is_prog;
         erase_r <= pulse_nxt & (is_page | is_mass);
         mass_r <= pulse_nxt & is_mass;
         verify_r <= pulse_nxt & is_blank;
         addr_out_r <= addr_out_nxt;
      end
   end

   // Interrupt status, mask and level output
   always_ff @(posedge clock) begin
      if (rst) begin
         irq_stat_r <= 2'b00;
         irq_mask_r <= fpes_pkg::IRQ_MASK_RESET;
         irq_r <= 1'b0;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         if (w_mask) begin
            irq_mask_r <= hwdata[1:0];
         end
         irq_r <= |(irq_stat_r & irq_mask_r);
      end
   end

   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp = hresp_r;
   assign array_program = prog_r;
   assign array_erase = erase_r;
   assign array_mass = mass_r;
   assign array_verify = verify_r;
   assign array_addr = addr_out_r;
   assign array_data = cur_data_r;
   assign irq = irq_r;
endmodule // fpes_sequencer

/* File: core/fpes_pkg.sv */
package fpes_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_DIVIDER = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_COMMAND = 8'h08;
   localparam logic [7:0] OFS_ADDRESS = 8'h0c;
   localparam logic [7:0] OFS_DATA = 8'h10;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   // Field positions
   localparam int DIV_LOADED_BIT = 31;
   localparam int ST_CBEF_BIT = 7;
   localparam int ST_CCF_BIT = 6;
   localparam int ST_ACCERR_BIT = 4;
   localparam int ST_BLANK_BIT = 2;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_ERR_BIT = 1;
   // Reset values
   localparam logic [31:0] DIVIDER_RESET = 32'h0000_0000;
   localparam logic [7:0] COMMAND_RESET = 8'h00;
   localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
   // Command codes
   localparam logic [7:0] CMD_BLANK = 8'h05;
   localparam logic [7:0] CMD_BYTE_PROG = 8'h20;
   localparam logic [7:0] CMD_BURST_PROG = 8'h25;
   localparam logic [7:0] CMD_PAGE_ERASE = 8'h40;
   localparam logic [7:0] CMD_MASS_ERASE = 8'h41;
   // Timing in flash timing clock periods, page size in bytes and counter width
   localparam int START_TICKS = 3;
   localparam int END_TICKS = 2;
   localparam int BYTE_PROG_TICKS = 9;
   localparam int BURST_BYTE_TICKS = 4;
   localparam int PAGE_ERASE_TICKS = 4000;
   localparam int MASS_ERASE_TICKS = 20000;
   localparam int BLANK_CHECK_TICKS = 1024;
   localparam int PAGE_BYTES = 512;
   localparam int CNT_W = 15;
   // Sequencer states, Gray along the path
   typedef enum logic [1:0] {
      FPES_IDLE = 2'b00,
      FPES_START = 2'b01,
      FPES_PULSE = 2'b11,
      FPES_FINISH = 2'b10
   } fpes_state_type;
endpackage

/* File: bench/fpes_props.sv */
module fpes_props #(
   parameter int PAGES = 64
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic stop_entry,
   input wire logic array_blank,
   input wire logic array_program,
   input wire logic array_erase,
   input wire logic array_mass,
   input wire logic array_verify,
   input wire logic [$clog2(PAGES*fpes_pkg::PAGE_BYTES)-1:0] array_addr,
   input wire logic [7:0] array_data,
   input wire logic irq
);
   logic busy_strobe;
   assign busy_strobe = array_program | array_erase | array_verify;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_quiet;
      !busy_strobe;
   endsequence
   sequence s_prog_hold;
      array_program [*4];
   endsequence
   // Pulses shorter than the minimum tick count would mean a miscounted phase
   AST_MASS_WITH_ERASE: assert property (array_mass |-> array_erase)
      else $error("mass strobe without erase strobe");
   AST_ONE_STROBE: assert property ($onehot0({array_program, array_erase, array_verify}))
      else $error("more than one array strobe");
   AST_PAGE_ALIGN: assert property (array_erase && !array_mass |-> array_addr[8:0] == 9'h000)
      else $error("page erase address not page aligned");
   AST_ERASE_ADDR_HOLD: assert property (array_erase && $past(array_erase) |-> $stable(array_addr))
      else $error("erase address moved during pulse");
   AST_STOP_ABORT: assert property (stop_entry && busy_strobe |=> s_quiet)
      else $error("strobe still high after stop entry");
   AST_RESET_QUIET: assert property ($fell(rst) |-> s_quiet [*4])
      else $error("strobe right after reset");
   AST_PROG_PULSE: assert property (disable iff (rst || stop_entry)
      $rose(array_program) |-> s_prog_hold) else $error("program pulse too short");
   AST_ERASE_PULSE: assert property (disable iff (rst || stop_entry)
      $rose(array_erase) |-> array_erase [*8]) else $error("erase pulse too short");
   AST_VERIFY_PULSE: assert property (disable iff (rst || stop_entry)
      $rose(array_verify) |-> array_verify [*8]) else $error("verify pulse too short");
endmodule // fpes_props

bind fpes_sequencer fpes_props #(.PAGES(PAGES)) u_props (.clock(clock), .rst(rst), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .stop_entry(stop_entry), .array_blank(array_blank), .array_program(array_program),
   .array_erase(array_erase), .array_mass(array_mass), .array_verify(array_verify),
   .array_addr(array_addr), .array_data(array_data), .irq(irq));

/* File: bench/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic stop_entry = 1'b0;
   logic array_blank = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hrdata, v;
   logic hready, hreadyout, hresp, array_program, array_erase, array_mass, array_verify, irq;
   logic [14:0] array_addr, ea;
   logic [7:0] array_data, pd;
   logic mass_seen = 1'b0;
   int fails = 0;
   int check_count = 0;
   int run = 0;
   int last_w = 0;
   logic [7:0] cmds [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
   int wid [5] = '{15, 4, 4, 15, 35};
   assign hready = hreadyout;
   always #2 clock = ~clock;
   // Short erase counts keep the run small; divider 0 gives one tick a clock
   fpes_sequencer #(.PAGE_ERASE_CYCLES(20), .MASS_ERASE_CYCLES(40),
      .BLANK_CHECK_CYCLES(20)) u_dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .stop_entry(stop_entry),
      .array_blank(array_blank), .array_program(array_program), .array_erase(array_erase),
      .array_mass(array_mass), .array_verify(array_verify), .array_addr(array_addr),
      .array_data(array_data), .irq(irq));
   always @(posedge clock) begin
      if (array_program | array_erase | array_verify) run <= run + 1;
      else if (run != 0) begin
         last_w <= run;
         run <= 0;
      end
      if (array_erase) ea <= array_addr;
      if (array_program) pd <= array_data;
      mass_seen <= mass_seen | array_mass;
   end
   task automatic summarize();
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      check_count++;
      if (seen !== want) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do begin
         @(posedge clock);
         n++;
      end while (hready !== 1'b1 && n < 99);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge clock);
         n++;
      end while (hready !== 1'b1 && n < 99);
      v = hrdata;
      if (n >= 99) begin
         fails++;
         summarize();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      bus(1'b0, a, 32'h0);
      check(v, want);
      check({31'h0, hresp}, 32'h0);
   endtask
   task automatic st(input int b, input logic e);
      bus(1'b0, fpes_pkg::OFS_STATUS, 32'h0);
      check({31'h0, v[b]}, {31'h0, e});
   endtask
   task automatic launch(input logic [7:0] c);
      wr(fpes_pkg::OFS_ADDRESS, 32'h234);
      wr(fpes_pkg::OFS_DATA, 32'ha5);
      wr(fpes_pkg::OFS_COMMAND, {24'h0, c});
      wr(fpes_pkg::OFS_STATUS, 32'h80);
   endtask
   task automatic wait_strobe();
      int k;
      k = 0;
      while (!(array_program | array_erase | array_verify) && k < 99) begin
         @(posedge clock);
         k++;
      end
      if (k >= 99) begin
         fails++;
         summarize();
      end
   endtask
   task automatic wait_done();
      int k;
      k = 0;
      wait_strobe();
      do begin
         bus(1'b0, fpes_pkg::OFS_STATUS, 32'h0);
         k++;
      end while (v[6] !== 1'b1 && k < 200);
      if (k >= 200) begin
         fails++;
         summarize();
      end
   endtask
   initial begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      launch(8'h20);
      st(4, 1'b1);
      rd(fpes_pkg::OFS_IRQ_STATUS, 32'h2);
      wr(fpes_pkg::OFS_DIVIDER, 32'h0);
      rd(fpes_pkg::OFS_DIVIDER, 32'h0);
      wr(fpes_pkg::OFS_STATUS, 32'h0);
      st(4, 1'b1);
      wr(fpes_pkg::OFS_STATUS, 32'h10);
      st(4, 1'b0);
      wr(fpes_pkg::OFS_DIVIDER, 32'h0);
      wr(fpes_pkg::OFS_DIVIDER, 32'h5);
      rd(fpes_pkg::OFS_DIVIDER, 32'h8000_0000);
      rd(8'h1c, 32'h0);
      wr(fpes_pkg::OFS_IRQ_MASK, 32'h1);
      array_blank <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         launch(cmds[i]);
         wait_done();
         check(32'(last_w), 32'(wid[i]));
         st(4, 1'b0);
         st(2, i == 0);
      end
      check({31'h0, irq}, 32'h1);
      check({24'h0, pd}, 32'ha5);
      check({17'h0, ea}, 32'h200);
      check({31'h0, mass_seen}, 32'h1);
      array_blank <= 1'b0;
      launch(8'h05);
      wait_done();
      st(2, 1'b0);
      rd(fpes_pkg::OFS_IRQ_STATUS, 32'h1);
      wr(fpes_pkg::OFS_STATUS, 32'h84);
      st(4, 1'b1);
      st(2, 1'b0);
      check({31'h0, irq}, 32'h0);
      wr(fpes_pkg::OFS_STATUS, 32'h10);
      launch(8'h33);
      st(4, 1'b1);
      wr(fpes_pkg::OFS_STATUS, 32'h10);
      launch(8'h40);
      wait_strobe();
      stop_entry <= 1'b1;
      repeat (2) @(posedge clock);
      stop_entry <= 1'b0;
      st(4, 1'b1);
      check({31'h0, array_erase}, 32'h0);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      wr(fpes_pkg::OFS_DIVIDER, 32'h1);
      launch(8'h20);
      wait_done();
      check(32'(last_w), 32'h8);
      summarize();
   end
endmodule // tb
